// File: rtl/seg_disp_params.svh
`ifndef SEG_DISP_PARAMS_SVH
`define SEG_DISP_PARAMS_SVH
// ****************************************
// Register byte offsets
// ****************************************
`define OFS_DISPLAY_CTRL     8'h00
`define OFS_FRAME_CTRL       8'h04
`define OFS_DISPLAY_STATUS   8'h08
`define OFS_FLAG_CLEAR       8'h0C
// ****************************************
// Display control fields
// ****************************************
`define CTRL_ENABLE_BIT      0
`define CTRL_STEPUP_BIT      1
`define CTRL_VOLTAGE_BUFFER_ENABLE_BIT       2
`define CTRL_UPDREQ_BIT      3
`define CTRL_WIDTH           3
// ****************************************
// Frame control fields
// ****************************************
`define FCR_HD_BIT           0
`define FCR_PON_LSB          1
`define FCR_CC_LSB           4
`define FCR_FRAME_START_IRQ_ENABLE_BIT        8
`define FCR_UPDATE_DONE_IRQ_ENABLE_BIT        9
`define FCR_WIDTH            10
// ****************************************
// Status and clear fields
// ****************************************
`define SR_ENS_BIT           0
`define SR_SOF_BIT           1
`define SR_UDR_BIT           2
`define SR_UDD_BIT           3
`define SR_RDY_BIT           4
`define SR_FRAME_CTRL_SYNC_FLAG_BIT         5
`define CLR_SOFC_BIT         1
`define CLR_UPDATE_DONE_CLEAR_BIT         3
// ****************************************
// Reset values and timing
// ****************************************
`define STATUS_RESET         32'h0000_0020
`define FCR_RESET            10'h000
`define CTRL_RESET           3'h0
`define FRAME_DIV_DEFAULT    1000
`endif

// File: rtl/seg_disp_pkg.sv
package seg_disp_pkg;
   // One-hot bus slave states
   typedef enum logic [1:0] {
      BUS_IDLE = 2'b01,
      BUS_ACK  = 2'b10
   } bus_state_t;
   // Frame configuration as driven onto the glass
   typedef logic [9:0] frame_cfg_t;
endpackage : seg_disp_pkg

// File: rtl/frame_link_if.sv
`timescale 1ns/1ps
interface frame_link_if;
   import seg_disp_pkg::*;
   frame_cfg_t cfg_word;     // Last written frame control
   logic       cfg_wr;       // Software wrote frame control
   frame_cfg_t active_cfg;   // Configuration of current frame
   logic       frame_start;  // One-cycle frame boundary
   logic       applied;      // Shadow loaded at this boundary
   modport ctrl (output cfg_word, output cfg_wr,
                 input active_cfg, input frame_start, input applied);
   modport seq  (input cfg_word, input cfg_wr,
                 output active_cfg, output frame_start, output applied);
endinterface : frame_link_if

// File: rtl/frame_sequencer.sv
`timescale 1ns/1ps
`include "seg_disp_params.svh"
module frame_sequencer #(
   parameter int FRAME_DIV = `FRAME_DIV_DEFAULT
) (
   // Clock and reset
   input wire logic     clk,
   input wire logic     rst_n,
   // Link to register side
   frame_link_if.seq    lnk
);
   import seg_disp_pkg::*;

   logic [31:0] cnt_r;
   logic        pending_r;
   logic        tick;
   logic        load;

   // Frame boundary and shadow load decision
   assign tick = (cnt_r == 32'(FRAME_DIV - 1));
   assign load = tick & pending_r & ~lnk.cfg_wr;

   // Frame rate divider
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= 32'h0000_0000;
      end else if (tick) begin
         cnt_r <= 32'h0000_0000;
      end else begin
         cnt_r <= cnt_r + 32'h0000_0001;
      end
   end

   // R01 pending until boundary
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pending_r <= 1'b0;
      end else if (lnk.cfg_wr) begin
         pending_r <= 1'b1;
      end else if (load) begin
         pending_r <= 1'b0;
      end
   end

   // R01 R02 shadow loads at boundary
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lnk.active_cfg  <= `FCR_RESET;
         lnk.frame_start <= 1'b0;
         lnk.applied     <= 1'b0;
      end else begin
         lnk.frame_start <= tick;
         lnk.applied     <= load;
         if (load) begin
            lnk.active_cfg <= lnk.cfg_word;
         end
      end
   end
endmodule : frame_sequencer

// File: rtl/segment_display_status_sync.sv
`timescale 1ns/1ps
`include "seg_disp_params.svh"
// Notes on behaviour
// R01 - Frame control drive fields apply at next frame start, IRQ enables at once
// R02 - Contrast stored now, driven next frame
// R03 - Frame control reads back last written value
// R04 - Buffer enable forces low divider off
// R05 - Sync flag sets on apply, clears on write
// R06 - Ready only when converter enabled and good
// R07 - Update done set wins over clear
// R08 - Update done with enable raises interrupt
// R09 - No update interrupt in stop mode
// R10 - No update interrupt while display disabled
// R11 - Status resets to sync flag only
// R12 - Status register writes are ignored
module segment_display_status_sync #(
   parameter int FRAME_DIV = `FRAME_DIV_DEFAULT
) (
   // Clock and reset
   input  wire logic        SYS_CLK,
   input  wire logic        RESETN,
   // Wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [7:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output      logic [31:0] WB_DAT_O,
   output      logic        WB_ACK_O,
   // Pins from outside the clock domain
   input  wire logic        STEPUP_OK,
   input  wire logic        STOP_MODE,
   // Drive configuration
   output      logic [2:0]  CONTRAST,
   output      logic [2:0]  PULSE_ON,
   output      logic        HIGH_DRIVE,
   output      logic        LOW_DIV_EN,
   output      logic        BUF_EN,
   output      logic        STEPUP_EN,
   output      logic        DISPLAY_EN,
   output      logic        FRAME_START,
   // Event requests
   output      logic        UPDATE_IRQ,
   output      logic        FRAME_IRQ
);
   import seg_disp_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   logic [1:0]  rst_sync_r;
   logic        rst_n;
   logic [1:0]  pin_in;
   logic [1:0]  pin_meta_r;
   logic [1:0]  pin_sync_r;
   logic        stepup_ok_s;
   logic        stop_s;

   bus_state_t  bus_r;
   bus_state_t  bus_nxt;
   logic [31:0] rdata;
   logic [31:0] dat_r;
   logic        req;
   logic        commit_wr;
   logic        hit_ctrl;
   logic        hit_fcr;
   logic        hit_sr;
   logic        hit_clr;
   logic        wr_ctrl;
   logic        wr_fcr;
   logic        wr_clr;
   logic [31:0] ctrl_merged;
   logic [31:0] fcr_merged;
   logic [31:0] clr_merged;

   logic [2:0]  ctrl_r;
   frame_cfg_t  fcr_r;
   logic        udr_r;
   logic        udr_nxt;
   logic        sof_r;
   logic        sof_nxt;
   logic        udd_r;
   logic        udd_nxt;
   logic        frame_ctrl_sync_flag_r;
   logic        frame_ctrl_sync_flag_nxt;
   logic        display_enabled_flag;
   logic        rdy;
   logic        udd_done;
   logic        udd_clr;
   logic        sof_clr;
   logic [31:0] status;
   logic        low_div_nxt;
   logic        upd_irq_nxt;
   logic        frm_irq_nxt;

   frame_link_if lnk ();

   // ****************************************
   // Helpers
   // ****************************************
   // Byte lane merge under Wishbone select
   function automatic logic [31:0] lane_merge(
      input logic [31:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0]  sel
   );
      logic [31:0] res;
      res = old_v;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            res[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return res;
   endfunction : lane_merge

   // Word-aligned address match
   function automatic logic addr_hit(
      input logic [7:0] adr,
      input logic [7:0] ofs
   );
      return (adr[7:2] == ofs[7:2]);
   endfunction : addr_hit

   // ****************************************
   // Reset and pin synchronisers
   // ****************************************
   // Reset release through two flops
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   assign pin_in = {STOP_MODE, STEPUP_OK};

   // Two-flop synchronisers for async pins
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_pin_sync
         always_ff @(posedge SYS_CLK or negedge rst_n) begin
            if (!rst_n) begin
               pin_meta_r[g] <= 1'b0;
               pin_sync_r[g] <= 1'b0;
            end else begin
               pin_meta_r[g] <= pin_in[g];
               pin_sync_r[g] <= pin_meta_r[g];
            end
         end
      end
   endgenerate

   assign stepup_ok_s = pin_sync_r[0];
   assign stop_s      = pin_sync_r[1];

   // ****************************************
   // Wishbone slave
   // ****************************************
   // Request, decode and commit strobes
   assign req       = WB_CYC_I & WB_STB_I;
   assign commit_wr = req & WB_WE_I & (bus_r == BUS_ACK);
   assign hit_ctrl  = addr_hit(WB_ADR_I, `OFS_DISPLAY_CTRL);
   assign hit_fcr   = addr_hit(WB_ADR_I, `OFS_FRAME_CTRL);
   assign hit_sr    = addr_hit(WB_ADR_I, `OFS_DISPLAY_STATUS);
   assign hit_clr   = addr_hit(WB_ADR_I, `OFS_FLAG_CLEAR);
   assign wr_ctrl   = commit_wr & hit_ctrl;
   // R01 writes accepted at any time
   assign wr_fcr    = commit_wr & hit_fcr;
   assign wr_clr    = commit_wr & hit_clr;

   // Merged write values
   assign ctrl_merged = lane_merge({29'h0, ctrl_r}, WB_DAT_I,
                                   WB_SEL_I);
   assign fcr_merged  = lane_merge({22'h0, fcr_r}, WB_DAT_I,
                                   WB_SEL_I);
   assign clr_merged  = lane_merge(32'h0000_0000, WB_DAT_I,
                                   WB_SEL_I);

   // R03 read returns written frame control
   assign rdata = hit_ctrl ? {28'h0, udr_r, ctrl_r} :
                  hit_fcr  ? {22'h0, fcr_r} :
                  hit_sr   ? status :
                  32'h0000_0000;

   // Next bus state
   always_comb begin
      bus_nxt = bus_r;
      case (bus_r)
         BUS_IDLE: begin
            if (req) begin
               bus_nxt = BUS_ACK;
            end
         end
         BUS_ACK: begin
            bus_nxt = BUS_IDLE;
         end
         default: begin
            bus_nxt = BUS_IDLE;
         end
      endcase
   end

   // Bus state and read data capture
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         bus_r <= BUS_IDLE;
         dat_r <= 32'h0000_0000;
      end else begin
         bus_r <= bus_nxt;
         if ((bus_r == BUS_IDLE) && req) begin
            dat_r <= rdata;
         end
      end
   end

   assign WB_ACK_O = (bus_r == BUS_ACK);
   assign WB_DAT_O = dat_r;

   // ****************************************
   // Software registers
   // ****************************************
   // R12 status writes fall through
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= `CTRL_RESET;
         fcr_r  <= `FCR_RESET;
      end else begin
         if (wr_ctrl) begin
            ctrl_r <= ctrl_merged[2:0];
         end
         if (wr_fcr) begin
            fcr_r <= fcr_merged[9:0];
         end
      end
   end

   assign display_enabled_flag = ctrl_r[`CTRL_ENABLE_BIT];

   // ****************************************
   // Frame sequencing
   // ****************************************
   assign lnk.cfg_word = fcr_r;
   assign lnk.cfg_wr   = wr_fcr;

   frame_sequencer #(
      .FRAME_DIV (FRAME_DIV)
   ) u_seq (
      .clk   (SYS_CLK),
      .rst_n (rst_n),
      .lnk   (lnk.seq)
   );

   // ****************************************
   // Status flags
   // ****************************************
   // Clear strobes from the clear register
   assign sof_clr  = wr_clr & clr_merged[`CLR_SOFC_BIT];
   assign udd_clr  = wr_clr & clr_merged[`CLR_UPDATE_DONE_CLEAR_BIT];
   assign udd_done = lnk.frame_start & udr_r & display_enabled_flag;

   // Update request raised by software
   assign udr_nxt = (wr_ctrl & ctrl_merged[`CTRL_UPDREQ_BIT] & display_enabled_flag) |
                    (udr_r & ~udd_done & display_enabled_flag);

   // R07 set wins over clear
   assign udd_nxt = udd_done | (udd_r & ~udd_clr);
   assign sof_nxt = (lnk.frame_start & display_enabled_flag) | (sof_r & ~sof_clr);

   // R05 set on apply, clear on write
   assign frame_ctrl_sync_flag_nxt = lnk.applied | (frame_ctrl_sync_flag_r & ~wr_fcr);

   // R06 ready needs converter on and good
   assign rdy = ctrl_r[`CTRL_STEPUP_BIT] & stepup_ok_s;

   // R11 flags reset to sync only
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         udr_r   <= 1'b0;
         udd_r   <= 1'b0;
         sof_r   <= 1'b0;
         frame_ctrl_sync_flag_r <= 1'(`STATUS_RESET >> `SR_FRAME_CTRL_SYNC_FLAG_BIT);
      end else begin
         udr_r   <= udr_nxt;
         udd_r   <= udd_nxt;
         sof_r   <= sof_nxt;
         frame_ctrl_sync_flag_r <= frame_ctrl_sync_flag_nxt;
      end
   end

   // Status word assembly, reserved bits zero
   always_comb begin
      status                = 32'h0000_0000;
      status[`SR_ENS_BIT]   = display_enabled_flag;
      status[`SR_SOF_BIT]   = sof_r;
      status[`SR_UDR_BIT]   = udr_r;
      status[`SR_UDD_BIT]   = udd_r;
      status[`SR_RDY_BIT]   = rdy;
      status[`SR_FRAME_CTRL_SYNC_FLAG_BIT] = frame_ctrl_sync_flag_r;
   end

   // ****************************************
   // Drive outputs and requests
   // ****************************************
   // R04 buffer forces low divider off
   assign low_div_nxt = ~ctrl_r[`CTRL_VOLTAGE_BUFFER_ENABLE_BIT] &
                        (lnk.active_cfg[`FCR_HD_BIT] |
                         (lnk.active_cfg[`FCR_PON_LSB +: 3] != 3'h0));

   // R08 R09 R10 update request gating
   assign upd_irq_nxt = udd_r & fcr_r[`FCR_UPDATE_DONE_IRQ_ENABLE_BIT] & display_enabled_flag & ~stop_s;
   // Frame start enable acts immediately
   assign frm_irq_nxt = sof_r & fcr_r[`FCR_FRAME_START_IRQ_ENABLE_BIT] & display_enabled_flag;

   // R02 contrast driven from frame shadow
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         CONTRAST    <= 3'h0;
         PULSE_ON    <= 3'h0;
         HIGH_DRIVE  <= 1'b0;
         LOW_DIV_EN  <= 1'b0;
         BUF_EN      <= 1'b0;
         STEPUP_EN   <= 1'b0;
         DISPLAY_EN  <= 1'b0;
         FRAME_START <= 1'b0;
      end else begin
         CONTRAST    <= lnk.active_cfg[`FCR_CC_LSB +: 3];
         PULSE_ON    <= lnk.active_cfg[`FCR_PON_LSB +: 3];
         HIGH_DRIVE  <= lnk.active_cfg[`FCR_HD_BIT];
         LOW_DIV_EN  <= low_div_nxt;
         BUF_EN      <= ctrl_r[`CTRL_VOLTAGE_BUFFER_ENABLE_BIT];
         STEPUP_EN   <= ctrl_r[`CTRL_STEPUP_BIT];
         DISPLAY_EN  <= display_enabled_flag;
         FRAME_START <= lnk.frame_start;
      end
   end

   // Registered interrupt requests
   always_ff @(posedge SYS_CLK or negedge rst_n) begin
      if (!rst_n) begin
         UPDATE_IRQ <= 1'b0;
         FRAME_IRQ  <= 1'b0;
      end else begin
         UPDATE_IRQ <= upd_irq_nxt;
         FRAME_IRQ  <= frm_irq_nxt;
      end
   end
endmodule : segment_display_status_sync

// File: testbench/segment_display_status_sync_sva.sv
`timescale 1ns/1ps
`include "seg_disp_params.svh"
// ******
// Port checker
// ******
module segment_display_status_sync_sva #(
   parameter int FRAME_DIV = `FRAME_DIV_DEFAULT
) (
   // Clock and reset
   input logic        SYS_CLK,
   input logic        RESETN,
   // Register bus
   input logic        WB_CYC_I,
   input logic        WB_STB_I,
   input logic        WB_WE_I,
   input logic [7:0]  WB_ADR_I,
   input logic [3:0]  WB_SEL_I,
   input logic [31:0] WB_DAT_I,
   input logic [31:0] WB_DAT_O,
   input logic        WB_ACK_O,
   // Pins and drive outputs
   input logic        STEPUP_OK,
   input logic        STOP_MODE,
   input logic [2:0]  CONTRAST,
   input logic [2:0]  PULSE_ON,
   input logic        HIGH_DRIVE,
   input logic        LOW_DIV_EN,
   input logic        BUF_EN,
   input logic        STEPUP_EN,
   input logic        DISPLAY_EN,
   input logic        FRAME_START,
   input logic        UPDATE_IRQ,
   input logic        FRAME_IRQ
);
   default clocking @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);
   // Status read being answered
   sequence s_stat_rd;
      WB_CYC_I && WB_STB_I && !WB_WE_I && WB_ADR_I[7:2] == 6'h02
         && WB_ACK_O;
   endsequence
   // Converter held off for a while
   sequence s_su_off;
      (!STEPUP_EN) [*5];
   endsequence
   // Ack one cycle after request
   property p_ack_next;
      WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O;
   endproperty
   a_ack_next: assert property (p_ack_next)
      else $error("ack not in next cycle");
   // Ack is a single pulse
   property p_ack_pulse;
      WB_ACK_O |=> !WB_ACK_O;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   property p_cfg_frame;
      $changed({CONTRAST, PULSE_ON, HIGH_DRIVE}) |-> FRAME_START;
   endproperty
   a_cfg_frame: assert property (p_cfg_frame)
      else $error("drive config changed off frame start");
   property p_contrast;
      (!FRAME_START) [*4] |-> $stable(CONTRAST);
   endproperty
   a_contrast: assert property (p_contrast)
      else $error("contrast changed inside frame");
   property p_lowdiv;
      BUF_EN && $past(BUF_EN) |-> !LOW_DIV_EN;
   endproperty
   a_lowdiv: assert property (p_lowdiv)
      else $error("low divider on with buffer");
   property p_ready;
      s_su_off ##0 s_stat_rd |-> !WB_DAT_O[4];
   endproperty
   a_ready: assert property (p_ready)
      else $error("ready with converter off");
   property p_status_rsv;
      s_stat_rd |-> WB_DAT_O[31:6] == 26'h0;
   endproperty
   a_status_rsv: assert property (p_status_rsv)
      else $error("reserved status bits set");
   // no update irq in stop mode
   property p_stop;
      STOP_MODE [*4] |-> !UPDATE_IRQ;
   endproperty
   a_stop: assert property (p_stop)
      else $error("update irq in stop mode");
   property p_dis;
      (!DISPLAY_EN) [*2] |-> !UPDATE_IRQ;
   endproperty
   a_dis: assert property (p_dis)
      else $error("update irq with display off");
endmodule : segment_display_status_sync_sva

bind segment_display_status_sync segment_display_status_sync_sva
   #(.FRAME_DIV(FRAME_DIV)) sva_u (.*);

// File: testbench/supply_glass_model.sv
`timescale 1ns/1ps
// ******
// Step-up supply beside the glass
// ******
module supply_glass_model #(
   parameter int SETTLE = 12
) (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst_n,
   // Supply control
   input  wire logic stepup_en,
   output      logic stepup_ok
);
   logic [7:0] cnt_r;
   // Settle count, restarts when disabled
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) cnt_r <= 8'h00;
      else if (!stepup_en) cnt_r <= 8'h00;
      else if (cnt_r != 8'(SETTLE)) cnt_r <= cnt_r + 8'h01;
   end
   // Voltage good only once settled
   assign stepup_ok = stepup_en && cnt_r == 8'(SETTLE);
endmodule : supply_glass_model

// File: testbench/tb_segment_display_status_sync.sv
`timescale 1ns/1ps
// ******
// Bench
// ******
module tb_segment_display_status_sync;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d, e;} row_t;
   localparam int FDIV = 64;
   logic        sys_clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0;
   logic        we = 1'b0, stop = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hF;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic [2:0]  contrast, pulse_on;
   logic        ack, ok, high_drive, low_div, buf_en, su_en, disp_en;
   logic        frm, upd_irq, frm_irq;
   int          err_total = 0, checks_done = 0;
   // Plain accesses and expected read data
   row_t rows [0:8] = '{
      '{1'b1, 8'h04, 32'h225, 32'h0},
      '{1'b0, 8'h04, 32'h0, 32'h225},
      '{1'b1, 8'h08, 32'hFFFFFFFF, 32'h0},
      '{1'b0, 8'h08, 32'h0, 32'h0},
      '{1'b1, 8'hF0, 32'hFFFFFFFF, 32'h0},
      '{1'b0, 8'hF0, 32'h0, 32'h0},
      '{1'b1, 8'h0C, 32'hFFFFFFFF, 32'h0},
      '{1'b0, 8'h0C, 32'h0, 32'h0},
      '{1'b0, 8'h00, 32'h0, 32'h0}};
   // Clock
   always #25 sys_clk = ~sys_clk;
   // Design and supply model
   segment_display_status_sync #(.FRAME_DIV(FDIV)) dut_u (
      .SYS_CLK(sys_clk), .RESETN(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
      .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
      .WB_DAT_O(dat_o), .WB_ACK_O(ack), .STEPUP_OK(ok), .STOP_MODE(stop),
      .CONTRAST(contrast), .PULSE_ON(pulse_on), .HIGH_DRIVE(high_drive),
      .LOW_DIV_EN(low_div), .BUF_EN(buf_en), .STEPUP_EN(su_en),
      .DISPLAY_EN(disp_en), .FRAME_START(frm), .UPDATE_IRQ(upd_irq),
      .FRAME_IRQ(frm_irq));
   supply_glass_model sup_u (.clk(sys_clk), .rst_n(rst_n),
      .stepup_en(su_en), .stepup_ok(ok));
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   // Classic bus cycle, read data into rdat
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge sys_clk);
      end while (ack !== 1'b1);
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      @(posedge sys_clk);
   endtask : bus
   // Wait whole cycles
   task automatic tick(input int k);
      repeat (k) @(posedge sys_clk);
   endtask : tick
   // Wait past the next frame start
   task automatic frame;
      int k;
      k = 0;
      while (frm !== 1'b1 && k < 200) begin
         @(posedge sys_clk);
         k++;
      end
      if (k >= 200) chk(32'h0, 32'h1);
      @(posedge sys_clk);
   endtask : frame
   // Verdict and end of run
   task automatic complete_run;
      if (err_total == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : complete_run
   // Watchdog
   initial begin
      repeat (5000) @(posedge sys_clk);
      chk(32'h0, 32'h1);
      complete_run;
   end
   // Main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      tick(3);
      bus(1'b0, 8'h08, 32'h0);
      chk(rdat, 32'h0000_0020);
      frame;
      foreach (rows[i]) begin
         bus(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(rdat, rows[i].e);
      end
      chk(contrast, 3'h0);
      frame;
      tick(3);
      chk({high_drive, pulse_on, contrast}, 7'h52);
      bus(1'b0, 8'h08, 32'h0);
      chk(rdat[5], 1'b1);
      bus(1'b1, 8'h00, 32'h4);
      tick(3);
      chk(low_div, 1'b0);
      bus(1'b1, 8'h00, 32'h0);
      tick(3);
      chk(low_div, 1'b1);
      bus(1'b1, 8'h00, 32'h2);
      bus(1'b0, 8'h08, 32'h0);
      chk(rdat[4], 1'b0);
      tick(20);
      bus(1'b0, 8'h08, 32'h0);
      chk(rdat[4], 1'b1);
      bus(1'b1, 8'h00, 32'h0);
      tick(4);
      bus(1'b0, 8'h08, 32'h0);
      chk(rdat[4], 1'b0);
      bus(1'b1, 8'h00, 32'h8);
      frame;
      frame;
      tick(3);
      bus(1'b0, 8'h08, 32'h0);
      chk({rdat[3], rdat[2], upd_irq}, 3'h0);
      bus(1'b1, 8'h00, 32'h1);
      bus(1'b1, 8'h00, 32'h9);
      frame;
      tick(3);
      chk(upd_irq, 1'b1);
      bus(1'b0, 8'h08, 32'h0);
      chk({rdat[3], rdat[2], rdat[0]}, 3'h5);
      bus(1'b1, 8'h04, 32'h025);
      tick(2);
      chk(upd_irq, 1'b0);
      bus(1'b1, 8'h04, 32'h225);
      tick(2);
      chk(upd_irq, 1'b1);
      stop <= 1'b1;
      tick(5);
      chk(upd_irq, 1'b0);
      stop <= 1'b0;
      tick(5);
      chk(upd_irq, 1'b1);
      bus(1'b1, 8'h0C, 32'h8);
      bus(1'b0, 8'h08, 32'h0);
      chk(rdat[3], 1'b0);
      // Clear lands on the edge that sets update done
      frame;
      bus(1'b1, 8'h00, 32'h9);
      tick(FDIV - 7);
      bus(1'b1, 8'h0C, 32'h8);
      bus(1'b0, 8'h08, 32'h0);
      chk(rdat[3], 1'b1);
      // Frame start enable acts at once
      frame;
      bus(1'b1, 8'h04, 32'h325);
      tick(2);
      chk(frm_irq, 1'b1);
      bus(1'b1, 8'h0C, 32'h2);
      tick(2);
      chk(frm_irq, 1'b0);
      // Byte lane write keeps the other lanes
      sel <= 4'h1;
      bus(1'b1, 8'h04, 32'hFFFF_FF00);
      sel <= 4'hF;
      bus(1'b0, 8'h04, 32'h0);
      chk(rdat, 32'h0000_0300);
      // Reset in mid-run
      rst_n <= 1'b0;
      tick(4);
      rst_n <= 1'b1;
      tick(3);
      bus(1'b0, 8'h08, 32'h0);
      chk(rdat, 32'h0000_0020);
      complete_run;
   end
endmodule : tb_segment_display_status_sync
